/* File: hw/rsw_clock_monitor.sv */
// supervised clock edge detector and self-timed clock monitor
`default_nettype none
module rsw_clock_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // supervised clock
  input wire logic eClk,
  input wire logic stopHalt,
  // control and result
  input wire logic monEnable,
  output logic eRise,
  output logic clockFail
);
  import rsw_pkg::*;

  logic eMid;
  logic eSync;
  logic eLast;
  logic [CLKMON_W-1:0] gap;
  logic [CLKMON_W-1:0] next_gap;
  logic next_fail;
  localparam logic [CLKMON_W-1:0] GapLimit = CLKMON_W'(CLKMON_LIMIT);

  // stop halts the supervised clock, so its edges no longer count
  assign eRise = eSync & ~eLast & ~stopHalt;

  always_comb begin
    next_gap = gap;
    if (eRise) begin
      next_gap = '0;
    end else if (gap != GapLimit) begin
      next_gap = gap + 1'b1;
    end
    // timed on the free reference, not on the clock being watched
    next_fail = monEnable && (next_gap == GapLimit);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eMid <= 1'b0;
      eSync <= 1'b0;
      eLast <= 1'b0;
      gap <= '0;
      clockFail <= 1'b0;
    end else begin
      eMid <= eClk;
      eSync <= eMid;
      eLast <= eSync;
      gap <= next_gap;
      clockFail <= next_fail;
    end
  end
endmodule : rsw_clock_monitor
`default_nettype wire

/* File: hw/rsw_pkg.sv */
// constants, types and register map of the reset sources and watchdog block
`default_nettype none
package rsw_pkg;
  // time base
  localparam int unsigned REF_HZ = 10_000_000;
  // sequencer counts, in supervised clock cycles
  localparam int unsigned POR_CYCLES = 4064;
  localparam int unsigned DRIVE_CYCLES = 4;
  localparam int unsigned SAMPLE_DELAY = 2;
  localparam int unsigned OPT_WINDOW = 64;
  localparam int unsigned WDOG_BASE_LOG2 = 15;
  localparam int unsigned SEQ_W = 12;
  localparam int unsigned WDOG_W = 21;
  // clock monitor: fail below this rate, never flag at or above the healthy rate
  localparam int unsigned CLKMON_FAIL_HZ = 10_000;
  localparam int unsigned CLKMON_OK_HZ = 200_000;
  // four healthy periods, well short of one failing period; longest time rounds down
  localparam int unsigned CLKMON_LIMIT = (REF_HZ * 4) / CLKMON_OK_HZ;
  localparam int unsigned CLKMON_W = 8;
  // apb
  localparam int unsigned PADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_STATUS = 16'h1030;
  localparam logic [15:0] IDX_OPTIONS = 16'h1039;
  localparam logic [15:0] IDX_SERVICE = 16'h103a;
  localparam logic [15:0] IDX_TEST = 16'h103e;
  // watchdog service keys
  localparam logic [7:0] WDOG_ARM_KEY = 8'h55;
  localparam logic [7:0] WDOG_CLEAR_KEY = 8'haa;
  // system_options fields
  localparam int unsigned OPT_IRQ_EDGE_SELECT = 5;
  localparam int unsigned OPT_CME = 3;
  localparam int unsigned OPT_CR_LSB = 0;
  localparam logic [7:0] OPT_RESET = 8'h10;
  localparam logic [7:0] OPT_IMPL_MASK = 8'hfb;
  localparam logic [7:0] OPT_ONCE_MASK = 8'h33;
  // test_control_reg fields
  localparam int unsigned TEST_DISABLE_RESETS_BIT = 2;
  // status fields
  localparam int unsigned ST_CAUSE_LSB = 0;
  localparam int unsigned ST_EXTERNAL = 2;
  localparam int unsigned ST_WDOG_EN = 3;
  localparam int unsigned ST_SPECIAL = 4;
  localparam int unsigned ST_OPT_LOCK = 5;
  localparam int unsigned ST_IRQ_PEND = 6;
  localparam int unsigned ST_ARMED = 7;
  // reset vectors, first byte of each pair
  localparam logic [7:0] VEC_HI_NORMAL = 8'hff;
  localparam logic [7:0] VEC_HI_SPECIAL = 8'hbf;
  localparam logic [7:0] VEC_LO_PIN = 8'hfe;
  localparam logic [7:0] VEC_LO_CLKMON = 8'hfc;
  localparam logic [7:0] VEC_LO_WDOG = 8'hfa;
  // synchroniser bank: resetPin, mode, watchdog_disable_bit, stop, irqPin
  localparam int unsigned NSYNC = 5;
  localparam logic [4:0] SYNC_INIT = 5'h11;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'h0,
    CAUSE_PIN = 2'h1,
    CAUSE_CLKMON = 2'h2,
    CAUSE_WDOG = 2'h3
  } rsw_cause_t;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_DRIVE = 3'h1,
    ST_SETTLE = 3'h3,
    ST_RUN = 3'h7,
    ST_HOLD = 3'h2
  } rsw_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_STATUS = 3'h1,
    SEL_OPTIONS = 3'h2,
    SEL_SERVICE = 3'h3,
    SEL_TEST = 3'h4
  } rsw_sel_t;
endpackage : rsw_pkg
`default_nettype wire

/* File: hw/rsw_reset_sources_watchdog.sv */
// reset sequencer, cause classification, watchdog and option registers
//
// Contract
// - after power-up hold reset for 4064 supervised clock cycles
// - if the reset pin is still low at the end, stay in reset until high
// - on any reset drive the reset pin low four cycles, then release it
// - sample the pin two cycles after release: low external, high internal
// - four sources; power-on and pin share a vector, others have their own
// - vector by cause and mode; upper byte bf in special modes, ff otherwise
// - priority: power-on or pin, then clock monitor, then watchdog
// - watchdog enable comes from the config bit and is taken only at reset
// - disable bit 0 enables watchdog resets, 1 suppresses them
// - in special modes watchdog resets start inhibited until disable bit cleared
// - watchdog period is 2^15 cycles times 1, 4, 16 or 64 by rate select
// - rate select resets to zero, the shortest period
// - normal modes: once-only option bits take one write in first 64 cycles
// - an enabled watchdog that times out starts a system reset
// - enabled monitor resets when no clock edges arrive within its own delay
// - below 10 kHz is a failure, 200 kHz and above never is
// - monitor enable resets to 0; 1 makes slow or stopped clocks reset
// - stopping the clock with the monitor enabled produces a reset
// - interrupt edge select 0 gives level, 1 gives falling edge only
//
// Our own choice: the APB slave port.
`default_nettype none
module rsw_reset_sources_watchdog #(
  parameter int unsigned PorCycles = rsw_pkg::POR_CYCLES,
  parameter int unsigned WdogBaseLog2 = rsw_pkg::WDOG_BASE_LOG2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsw_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supervised clock and stop request
  input wire logic eClk,
  input wire logic stopReq,
  // reset pin, open drain
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  // mode strap and nonvolatile config bit
  input wire logic modeSpecial,
  input wire logic watchdogDisableBit,
  // interrupt pin, active low
  input wire logic irqPinN,
  output logic irqRequest,
  // processor side
  output logic cpuResetN,
  output logic [15:0] vectorAddr,
  output logic [1:0] resetCause
);
  import rsw_pkg::*;

  // synchronisers
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncMid;
  logic [NSYNC-1:0] syncOut;
  assign rawIn = {irqPinN, stopReq, watchdogDisableBit, modeSpecial, resetPinIn};

  genvar g;
  for (g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        syncMid[g] <= SYNC_INIT[g];
        syncOut[g] <= SYNC_INIT[g];
      end else begin
        syncMid[g] <= rawIn[g];
        syncOut[g] <= syncMid[g];
      end
    end
  end

  logic pinLow;
  logic modeSync;
  logic noCopSync;
  logic stopSync;
  logic irqSync;
  assign pinLow = ~syncOut[0];
  assign modeSync = syncOut[1];
  assign noCopSync = syncOut[2];
  assign stopSync = syncOut[3];
  assign irqSync = syncOut[4];

  // state
  rsw_state_t state, next_state;
  rsw_cause_t cause, next_cause;
  logic [SEQ_W-1:0] seqCount, next_seqCount;
  logic external, next_external;
  logic pinDrive, next_pinDrive;
  logic special, next_special;
  logic copEnable, next_copEnable;
  logic [7:0] options, next_options;
  logic disable_resets_bit, next_disable_resets_bit;
  logic armed, next_armed;
  logic [WDOG_W-1:0] copCount, next_copCount;
  logic optLocked, next_optLocked;
  logic [6:0] winCount, next_winCount;
  logic irqPending, next_irqPending;
  logic irqPrev;
  logic next_irqRequest;
  logic next_cpuResetN;
  logic [15:0] next_vector;
  logic [31:0] next_prdata;

  logic eRise;
  logic clkFail;
  logic inReset;
  logic wdogActive;
  logic wdogTimeout;
  logic [WDOG_W-1:0] wdogEnd;
  logic setup;
  logic access;
  logic wr;
  rsw_sel_t sel;
  logic [7:0] wbyte;
  logic optWriteOk;
  logic [7:0] statusWord;

  rsw_clock_monitor u_clock_monitor (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .eClk(eClk),
    .stopHalt(stopSync),
    .monEnable(options[OPT_CME]),
    .eRise(eRise),
    .clockFail(clkFail)
  );

  function automatic rsw_sel_t regSel(input logic [PADDR_W-1:0] a);
    rsw_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[PADDR_W-1:2])
        IDX_STATUS: s = SEL_STATUS;
        IDX_OPTIONS: s = SEL_OPTIONS;
        IDX_SERVICE: s = SEL_SERVICE;
        IDX_TEST: s = SEL_TEST;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : regSel

  // last count of a watchdog period: 2^base times 1, 4, 16 or 64
  function automatic logic [WDOG_W-1:0] wdogLimit(input logic [1:0] cr);
    logic [63:0] span;
    span = 64'h1 << (WdogBaseLog2 + 2 * int'(cr));
    return WDOG_W'(span - 64'h1);
  endfunction : wdogLimit

  // apb decode: one setup cycle, then an access cycle with no wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign sel = regSel(paddr);
  assign wbyte = pwdata[7:0];
  assign pready = access;
  assign pslverr = access & (sel == SEL_NONE);

  assign inReset = (state != ST_RUN);
  assign wdogEnd = wdogLimit(options[OPT_CR_LSB +: 2]);
  // special modes keep watchdog resets off until the disable bit is cleared
  assign wdogActive = copEnable & ~(special & disable_resets_bit);
  assign wdogTimeout = wdogActive & eRise & (copCount == wdogEnd);
  assign optWriteOk = special | (~optLocked & (winCount < 7'(OPT_WINDOW)));

  // sequencer
  always_comb begin
    next_state = state;
    next_seqCount = seqCount;
    next_cause = cause;
    next_external = external;
    next_pinDrive = pinDrive;
    unique case (state)
      ST_POR: begin
        if (eRise) begin
          if (seqCount == SEQ_W'(PorCycles - 1)) begin
            next_state = ST_DRIVE;
            next_seqCount = '0;
            next_pinDrive = 1'b1;
          end else begin
            next_seqCount = seqCount + 1'b1;
          end
        end
      end
      ST_DRIVE: begin
        if (eRise) begin
          if (seqCount == SEQ_W'(DRIVE_CYCLES - 1)) begin
            next_state = ST_SETTLE;
            next_seqCount = '0;
            next_pinDrive = 1'b0;
          end else begin
            next_seqCount = seqCount + 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (eRise) begin
          if (seqCount == SEQ_W'(SAMPLE_DELAY - 1)) begin
            next_seqCount = '0;
            if (pinLow) begin
              next_state = ST_HOLD;
              next_external = 1'b1;
              next_cause = (cause == CAUSE_POR) ? CAUSE_POR : CAUSE_PIN;
            end else begin
              next_state = ST_RUN;
              next_external = 1'b0;
            end
          end else begin
            next_seqCount = seqCount + 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // an external circuit may keep the part in reset indefinitely
        if (!pinLow) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pinLow || clkFail || wdogTimeout) begin
          next_state = ST_DRIVE;
          next_seqCount = '0;
          next_pinDrive = 1'b1;
          if (pinLow) begin
            next_cause = CAUSE_PIN;
          end else if (clkFail) begin
            next_cause = CAUSE_CLKMON;
          end else begin
            next_cause = CAUSE_WDOG;
          end
        end
      end
      default: begin
        next_state = ST_POR;
        next_seqCount = '0;
        next_pinDrive = 1'b0;
      end
    endcase
  end

  // strap and enable are only taken while in reset
  always_comb begin
    next_special = inReset ? modeSync : special;
    next_copEnable = inReset ? ~noCopSync : copEnable;
    next_cpuResetN = (next_state == ST_RUN);
    next_vector[15:8] = special ? VEC_HI_SPECIAL : VEC_HI_NORMAL;
    unique case (cause)
      CAUSE_CLKMON: next_vector[7:0] = VEC_LO_CLKMON;
      CAUSE_WDOG: next_vector[7:0] = VEC_LO_WDOG;
      default: next_vector[7:0] = VEC_LO_PIN;
    endcase
  end

  // software registers and watchdog
  always_comb begin
    next_options = options;
    next_disable_resets_bit = disable_resets_bit;
    next_armed = armed;
    next_copCount = copCount;
    next_optLocked = optLocked;
    next_winCount = winCount;
    next_irqPending = irqPending;
    if (inReset) begin
      next_options = OPT_RESET;
      next_disable_resets_bit = 1'b1;
      next_armed = 1'b0;
      next_copCount = '0;
      next_optLocked = 1'b0;
      next_winCount = '0;
    end else begin
      if (eRise && winCount < 7'(OPT_WINDOW)) begin
        next_winCount = winCount + 1'b1;
      end
      if (eRise) begin
        next_copCount = (copCount == wdogEnd) ? '0 : copCount + 1'b1;
      end
      if (wr && sel == SEL_SERVICE) begin
        if (wbyte == WDOG_ARM_KEY) begin
          next_armed = 1'b1;
        end else if (wbyte == WDOG_CLEAR_KEY && armed) begin
          next_armed = 1'b0;
          next_copCount = '0;
        end
        // any other value leaves both the arm and the count alone
      end
      if (wr && sel == SEL_OPTIONS) begin
        next_options = (options & OPT_ONCE_MASK) | (wbyte & OPT_IMPL_MASK & ~OPT_ONCE_MASK);
        if (optWriteOk) begin
          next_options = wbyte & OPT_IMPL_MASK;
          next_optLocked = ~special;
        end
      end
      if (wr && sel == SEL_TEST && special) begin
        next_disable_resets_bit = wbyte[TEST_DISABLE_RESETS_BIT];
      end
    end
    if (wr && sel == SEL_STATUS && wbyte[ST_IRQ_PEND]) begin
      next_irqPending = 1'b0;
    end
    // a falling edge in the clearing cycle still counts
    if (irqPrev && !irqSync) begin
      next_irqPending = 1'b1;
    end
    next_irqRequest = options[OPT_IRQ_EDGE_SELECT] ? next_irqPending : ~irqSync;
  end

  // read data is captured in the setup cycle
  always_comb begin
    statusWord = '0;
    statusWord[ST_CAUSE_LSB +: 2] = cause;
    statusWord[ST_EXTERNAL] = external;
    statusWord[ST_WDOG_EN] = wdogActive;
    statusWord[ST_SPECIAL] = special;
    statusWord[ST_OPT_LOCK] = optLocked;
    statusWord[ST_IRQ_PEND] = irqPending;
    statusWord[ST_ARMED] = armed;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = '0;
      if (!pwrite) begin
        unique case (sel)
          SEL_STATUS: next_prdata[7:0] = statusWord;
          SEL_OPTIONS: next_prdata[7:0] = options;
          SEL_TEST: next_prdata[TEST_DISABLE_RESETS_BIT] = special & disable_resets_bit;
          default: next_prdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_POR;
      cause <= CAUSE_POR;
      seqCount <= '0;
      external <= 1'b0;
      pinDrive <= 1'b0;
      special <= 1'b0;
      copEnable <= 1'b0;
      options <= OPT_RESET;
      disable_resets_bit <= 1'b1;
      armed <= 1'b0;
      copCount <= '0;
      optLocked <= 1'b0;
      winCount <= '0;
      irqPending <= 1'b0;
      irqPrev <= 1'b1;
      irqRequest <= 1'b0;
      cpuResetN <= 1'b0;
      vectorAddr <= {VEC_HI_NORMAL, VEC_LO_PIN};
      prdata <= '0;
    end else begin
      state <= next_state;
      cause <= next_cause;
      seqCount <= next_seqCount;
      external <= next_external;
      pinDrive <= next_pinDrive;
      special <= next_special;
      copEnable <= next_copEnable;
      options <= next_options;
      disable_resets_bit <= next_disable_resets_bit;
      armed <= next_armed;
      copCount <= next_copCount;
      optLocked <= next_optLocked;
      winCount <= next_winCount;
      irqPending <= next_irqPending;
      irqPrev <= irqSync;
      irqRequest <= next_irqRequest;
      cpuResetN <= next_cpuResetN;
      vectorAddr <= next_vector;
      prdata <= next_prdata;
    end
  end

  // open drain: only ever pulls low
  assign resetPinOut = 1'b0;
  assign resetPinOe = pinDrive;
  assign resetCause = cause;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_por_held: assert property (state == ST_POR |-> !cpuResetN)
    else $error("processor released during power-up count");
  a_pin_holds: assert property (state == ST_HOLD && pinLow |=> state == ST_HOLD && !cpuResetN)
    else $error("left reset while pin low");
  a_pin_drive: assert property ($rose(resetPinOe) |-> state == ST_DRIVE && seqCount == '0)
    else $error("pin drive not aligned with drive phase");
  a_drive_len: assert property (state == ST_DRIVE && eRise && seqCount == SEQ_W'(DRIVE_CYCLES - 1)
    |=> !resetPinOe && state == ST_SETTLE)
    else $error("pin not released after four cycles");
  a_sample_class: assert property (state == ST_SETTLE && eRise && seqCount == SEQ_W'(1) && pinLow
    |=> state == ST_HOLD && external)
    else $error("low pin not classed external");
  a_vector_mode: assert property ($rose(cpuResetN)
    |-> vectorAddr[15:8] == (special ? VEC_HI_SPECIAL : VEC_HI_NORMAL))
    else $error("vector upper byte wrong for mode");
  a_cause_prio: assert property (state == ST_RUN && pinLow && (clkFail || wdogTimeout)
    |=> cause == CAUSE_PIN)
    else $error("pin reset lost priority");
  a_wdog_reset: assert property (state == ST_RUN && wdogTimeout && !pinLow && !clkFail
    |=> state == ST_DRIVE && cause == CAUSE_WDOG ##1 resetPinOe)
    else $error("watchdog timeout did not reset");
  a_bad_key: assert property (wr && sel == SEL_SERVICE && !inReset && wbyte != WDOG_ARM_KEY
    && wbyte != WDOG_CLEAR_KEY |=> armed == $past(armed))
    else $error("bad key changed the arm state");
  a_opt_lock: assert property (wr && sel == SEL_OPTIONS && !inReset && optLocked && !special
    |=> options[1:0] == $past(options[1:0]))
    else $error("locked rate select changed");
  a_reset_opts: assert property (inReset |=> options[1:0] == 2'h0 && !options[OPT_CME])
    else $error("options not cleared in reset");
  a_irq_level: assert property (!options[OPT_IRQ_EDGE_SELECT] && !$past(options[OPT_IRQ_EDGE_SELECT])
    |-> irqRequest == !$past(irqSync))
    else $error("level interrupt does not follow pin");

  c_wdog_reset: cover property (state == ST_RUN ##1 state == ST_DRIVE && cause == CAUSE_WDOG);
  c_clk_reset: cover property (state == ST_RUN ##1 state == ST_DRIVE && cause == CAUSE_CLKMON);
  c_external: cover property (state == ST_SETTLE ##1 state == ST_HOLD);
  c_serviced: cover property (wr && sel == SEL_SERVICE && armed && wbyte == WDOG_CLEAR_KEY);
endmodule : rsw_reset_sources_watchdog
`default_nettype wire

/* File: verif/rsw_reset_circuit.sv */
// external reset circuit: open-drain reset line with pull-up
`default_nettype none
module rsw_reset_circuit (
  // device side of the pin
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  // external reset source and resolved pin level
  input wire logic holdLow,
  output logic resetPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins only while neither party pulls low
  assign resetPinIn = ~((resetPinOe & ~resetPinOut) | holdLow);
endmodule : rsw_reset_circuit
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the reset sources and watchdog block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rsw_pkg::*;
  localparam int unsigned Por = 16;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, resetPinIn, resetPinOut, resetPinOe, irqRequest, cpuResetN;
  logic eRun = 1'b1;
  logic stopReq = 1'b0;
  logic holdLow = 1'b0;
  logic modeSpecial = 1'b0;
  logic wdogOff = 1'b1;
  logic irqPinN = 1'b1;
  logic [1:0] eDiv = 2'h0;
  logic eClk;
  logic [15:0] vectorAddr;
  logic [1:0] resetCause;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checkCount = 0;
  int eCount = 0;
  int oeCycles = 0;
  int n, s;

  always #50 ref_clk = ~ref_clk;
  // supervised clock at a quarter of the reference; stands still when stopped
  always @(posedge ref_clk) if (eRun) eDiv <= eDiv + 2'h1;
  assign eClk = eDiv[1];
  always @(posedge eClk) eCount <= eCount + 1;
  always @(posedge ref_clk) if (resetPinOe === 1'b1) oeCycles <= oeCycles + 1;

  rsw_reset_sources_watchdog #(.PorCycles(Por), .WdogBaseLog2(4)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eClk(eClk), .stopReq(stopReq), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .modeSpecial(modeSpecial), .watchdogDisableBit(wdogOff),
    .irqPinN(irqPinN), .irqRequest(irqRequest), .cpuResetN(cpuResetN),
    .vectorAddr(vectorAddr), .resetCause(resetCause)
  );

  rsw_reset_circuit partner (
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .holdLow(holdLow),
    .resetPinIn(resetPinIn)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rng(input int v, input int lo, input int hi, input string what);
    checkCount++;
    if (v < lo || v > hi) begin
      errors++;
      $display("BAD %0t %s out of range %0d", $time, what, v);
    end
  endtask : rng

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1, "bus no answer");
  endtask : apb

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 8'h0);
    chk(rd, exp, what);
  endtask : rd_chk

  // bounded wait for the processor reset line; n holds the cycles taken
  task automatic until_rst(input logic v, input int lim);
    n = 0;
    while (cpuResetN !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, cpuResetN}, {31'h0, v}, "reset line");
  endtask : until_rst

  task automatic irq_pulse(input logic expAfter);
    @(posedge ref_clk);
    irqPinN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, irqRequest}, 32'h1, "irq while low");
    irqPinN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, irqRequest}, {31'h0, expAfter}, "irq after high");
  endtask : irq_pulse

  task automatic cause_is(input rsw_cause_t c, input logic [7:0] lo);
    chk({30'h0, resetCause}, {30'h0, c}, "cause");
    chk({16'h0, vectorAddr}, {16'h0, VEC_HI_NORMAL, lo}, "vector");
  endtask : cause_is

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    until_rst(1'b1, 400);
    rng(n, (Por + 6) * 4 - 4, (Por + 6) * 4 + 12, "power-up hold");
    rng(oeCycles, 12, 18, "pin drive");
    cause_is(CAUSE_POR, VEC_LO_PIN);
    $display("test power-up done");
    rd_chk(IDX_OPTIONS, {24'h0, OPT_RESET}, "options reset");
    apb(1'b1, IDX_OPTIONS, 8'h31);
    rd_chk(IDX_OPTIONS, 32'h31, "options first write");
    apb(1'b1, IDX_OPTIONS, 8'h18);
    rd_chk(IDX_OPTIONS, 32'h39, "options second write");
    rd_chk(IDX_SERVICE, 32'h0, "service read");
    apb(1'b0, 16'h1031, 8'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    irq_pulse(1'b1);
    $display("test registers done");
    // enable bit changed while running must wait for the next reset
    wdogOff <= 1'b0;
    repeat (80) @(posedge eClk);
    chk({31'h0, cpuResetN}, 32'h1, "watchdog still off");
    $display("test enable latch done");
    @(posedge ref_clk);
    holdLow <= 1'b1;
    until_rst(1'b0, 20);
    repeat (60) @(posedge ref_clk);
    chk({31'h0, cpuResetN}, 32'h0, "held by pin");
    holdLow <= 1'b0;
    until_rst(1'b1, 40);
    cause_is(CAUSE_PIN, VEC_LO_PIN);
    apb(1'b0, IDX_STATUS, 8'h0);
    chk({31'h0, rd[ST_EXTERNAL]}, 32'h1, "external class");
    irq_pulse(1'b0);
    $display("test pin reset done");
    // service first: the shortest period starts counting at release from reset
    repeat (6) begin
      apb(1'b1, IDX_SERVICE, WDOG_ARM_KEY);
      apb(1'b1, IDX_SERVICE, WDOG_CLEAR_KEY);
      repeat (10) @(posedge eClk);
    end
    chk({31'h0, cpuResetN}, 32'h1, "serviced");
    apb(1'b1, IDX_SERVICE, WDOG_ARM_KEY);
    apb(1'b1, IDX_SERVICE, WDOG_CLEAR_KEY);
    s = eCount;
    // wrong key then an unarmed clear: the timer must keep running
    apb(1'b1, IDX_SERVICE, 8'h54);
    apb(1'b1, IDX_SERVICE, WDOG_CLEAR_KEY);
    until_rst(1'b0, 200);
    rng(eCount - s, 14, 18, "watchdog period");
    until_rst(1'b1, 100);
    cause_is(CAUSE_WDOG, VEC_LO_WDOG);
    apb(1'b0, IDX_STATUS, 8'h0);
    chk({31'h0, rd[ST_EXTERNAL]}, 32'h0, "internal class");
    $display("test watchdog done");
    apb(1'b1, IDX_OPTIONS, 8'h1b);
    @(posedge ref_clk);
    stopReq <= 1'b1;
    eRun <= 1'b0;
    until_rst(1'b0, 400);
    rng(n, 190, 215, "monitor delay");
    stopReq <= 1'b0;
    eRun <= 1'b1;
    until_rst(1'b1, 200);
    cause_is(CAUSE_CLKMON, VEC_LO_CLKMON);
    rd_chk(IDX_OPTIONS, {24'h0, OPT_RESET}, "monitor off");
    @(posedge ref_clk);
    eRun <= 1'b0;
    repeat (300) @(posedge ref_clk);
    chk({31'h0, cpuResetN}, 32'h1, "stop ignored");
    $display("test clock monitor done");
    eRun <= 1'b1;
    modeSpecial <= 1'b1;
    holdLow <= 1'b1;
    until_rst(1'b0, 20);
    holdLow <= 1'b0;
    until_rst(1'b1, 100);
    chk({16'h0, vectorAddr}, {16'h0, VEC_HI_SPECIAL, VEC_LO_PIN}, "special vector");
    rd_chk(IDX_TEST, 32'h4, "resets inhibited");
    repeat (40) @(posedge eClk);
    chk({31'h0, cpuResetN}, 32'h1, "special watchdog off");
    apb(1'b1, IDX_TEST, 8'h00);
    until_rst(1'b0, 200);
    chk({30'h0, resetCause}, {30'h0, CAUSE_WDOG}, "special watchdog cause");
    $display("test special mode done");
    wrap_up;
  end

  // the tests need under two thousand cycles; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("BAD %0t run did not finish", $time);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
